/* File: hw/tfa_pkg.sv */
// Package of constants and carrier types for the frame timing and input alignment block
package tfa_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] TFA_CTRL_OFS = 12'h000;
  localparam logic [11:0] TFA_STAT_OFS = 12'h004;
  localparam logic [11:0] TFA_LID_BASE = 12'h040;
  localparam logic [11:0] TFA_BID_BASE = 12'h080;
  localparam logic [11:0] TFA_BANK_MASK = 12'hFC0;
  localparam int TFA_STREAMS = 16;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] TFA_CTRL_RST = 8'h00;
  localparam logic [4:0] TFA_DELAY_RST = 5'h00;
  localparam logic [9:0] TFA_EDGE_LAST = 10'h3FF;
  localparam logic [9:0] TFA_EDGE_PRE = 10'h3FE;
  localparam logic [9:0] TFA_EDGE_NEAR = 10'h001;
  localparam logic [3:0] TFA_LVL_RST = 4'h8;
  localparam logic [3:0] TFA_LVL_MAX = 4'hF;
  localparam logic [1:0] TFA_BANK_LAST = 2'h2;
  localparam logic [2:0] TFA_FP8_SINGLE = 3'h2;
  localparam logic [2:0] TFA_FP8_DOUBLE = 3'h4;
  localparam logic [2:0] TFA_FP16_SINGLE = 3'h1;
  localparam logic [2:0] TFA_FP16_DOUBLE = 3'h2;
  localparam logic [5:0] TFA_FRAC_BASE = 6'h03;
  localparam logic [2:0] TFA_MODE_FULL = 3'h7;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Control word, bit 0 is pulse_width_sel
  typedef struct packed {
    logic sample_mode_sel;
    logic [2:0] discriminator_mode;
    logic discriminator_enable;
    logic out_clock_polarity_sel;
    logic in_clock_edge_sel;
    logic pulse_width_sel;
  } tfa_ctrl_t;

  // Connection memory entry of one output channel
  typedef struct packed {
    logic msg_mode_bit;
    logic out_enable_bit;
    logic source_sel_bit;
    logic [7:0] msg_byte;
  } tfa_cm_t;

  // Switched channel byte with its active-low drive enable
  typedef struct packed {
    logic [7:0] data;
    logic oe_n;
  } tfa_swout_t;

  typedef logic [2*TFA_STREAMS-1:0][5:0] tfa_pos_t;

endpackage : tfa_pkg

/* File: hw/tfa_frame_align.sv */
// Frame timing, input alignment and output channel control of a TDM switch
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module tfa_frame_align
  import tfa_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic master_clock_in,
  input wire logic master_frame_pulse_in,
  output logic frame_pulse_out_8m,
  output logic frame_pulse_out_16m,
  output logic clock_out_8m,
  output logic clock_out_16m,
  output logic [8:0] channel_num,
  output logic [1:0] wr_bank,
  output logic [1:0] rd_bank,
  output tfa_pos_t sample_pos,
  input wire tfa_cm_t local_cm,
  input wire tfa_cm_t bp_cm,
  input wire logic [7:0] local_dm_byte,
  input wire logic [7:0] bp_dm_byte,
  output tfa_swout_t local_out,
  output tfa_swout_t bp_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_d;
    logic fp_s1;
    logic fp_s2;
    logic [3:0] lvl;
    logic [1:0] pcnt;
    logic [9:0] edge_cnt;
    logic [1:0] bank;
    logic locked;
    logic miss;
    logic [7:0] half_cnt;
    logic [7:0] half_len;
    logic cflip;
    logic c8;
    logic c16;
    logic [2:0] fp8_hold;
    logic [2:0] fp16_hold;
    logic fp8_o;
    logic fp16_o;
    logic [8:0] chan;
    logic [1:0] rbank;
    tfa_ctrl_t ctrl;
    tfa_ctrl_t ctrl_act;
    logic [TFA_STREAMS-1:0][4:0] lid;
    logic [TFA_STREAMS-1:0][4:0] bid;
    tfa_pos_t smp;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    tfa_swout_t lout;
    tfa_swout_t bout;
  } tfa_state_t;

  tfa_state_t state_reg;
  tfa_state_t state_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Sample position in quarter bits from one delay field
  function automatic logic [5:0] tfa_pos(input logic [4:0] fld, input logic smode);
    logic [5:0] pt;
    pt = 6'h00;
    if (!smode) begin
      pt = TFA_FRAC_BASE + {1'b0, fld};
    end else begin
      unique case (fld[1:0])
        2'b00: pt = 6'h03;
        2'b01: pt = 6'h04;
        2'b10: pt = 6'h01;
        2'b11: pt = 6'h02;
      endcase
      pt = pt + {1'b0, fld[4:2], 2'b00};
    end
    return pt;
  endfunction : tfa_pos

  // Switch one output channel
  function automatic tfa_swout_t tfa_sw(input tfa_cm_t cm, input logic [7:0] ldm,
                                        input logic [7:0] bdm);
    tfa_swout_t o;
    o.data = cm.msg_mode_bit ? cm.msg_byte : (cm.source_sel_bit ? bdm : ldm);
    o.oe_n = ~cm.out_enable_bit;
    return o;
  endfunction : tfa_sw

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic rise;
  logic fall;
  logic any_edge;
  logic act;
  logic pulse_on;
  logic [1:0] pcnt_new;
  logic bnd;
  logic wrap;
  logic near;
  logic realign;
  logic start;
  logic aphase;
  logic [11:0] a;
  logic [4:0] fld;

  always_comb begin
    state_next = state_reg;
    fld = 5'h00;
    // Two-flop synchronisers on the link pins
    // The link clock is slow against hclk, so one more flop is enough to find
    // its edges; pulse and clock share the same two-flop latency
    state_next.clk_s1 = master_clock_in;
    state_next.clk_s2 = state_reg.clk_s1;
    state_next.clk_d = state_reg.clk_s2;
    state_next.fp_s1 = master_frame_pulse_in;
    state_next.fp_s2 = state_reg.fp_s1;
    rise = state_reg.clk_s2 & ~state_reg.clk_d;
    fall = ~state_reg.clk_s2 & state_reg.clk_d;
    any_edge = rise | fall;
    act = state_reg.ctrl_act.in_clock_edge_sel ? rise : fall;

    // Style: the idle level is the one seen most, the pulse is the other
    // The saturating counter needs a run of one level before it flips, so a
    // short burst of stray samples cannot swap the detected style
    if (act && state_reg.fp_s2 && state_reg.lvl != TFA_LVL_MAX) begin
      state_next.lvl = state_reg.lvl + 4'h1;
    end else if (act && !state_reg.fp_s2 && state_reg.lvl != 4'h0) begin
      state_next.lvl = state_reg.lvl - 4'h1;
    end
    pulse_on = state_reg.fp_s2 ^ state_reg.lvl[3];
    pcnt_new = state_reg.pcnt;
    if (act) begin
      pcnt_new = pulse_on ? ((state_reg.pcnt == 2'h3) ? 2'h3 : state_reg.pcnt + 2'h1) : 2'h0;
    end
    state_next.pcnt = pcnt_new;
    // Double-width pulse marks the boundary at its second sample
    bnd = act && pulse_on && state_reg.pcnt != pcnt_new &&
          pcnt_new == (state_reg.ctrl_act.pulse_width_sel ? 2'h2 : 2'h1);

    // Frame counter flywheels; pulses realign it as the discriminator allows
    // Mode 111 trades one frame of drift for immunity to a lone stray pulse;
    // mode 000 and the reserved codes follow every pulse at once
    wrap = state_reg.edge_cnt == TFA_EDGE_LAST;
    near = wrap || state_reg.edge_cnt == TFA_EDGE_PRE || state_reg.edge_cnt <= TFA_EDGE_NEAR;
    realign = 1'b0;
    if (act) begin
      state_next.edge_cnt = state_reg.edge_cnt + 10'h001;
    end
    if (bnd) begin
      if (!state_reg.ctrl_act.discriminator_enable) begin
        realign = 1'b1;
      end else if (near) begin
        realign = 1'b1;
        state_next.miss = 1'b0;
      end else if (state_reg.ctrl_act.discriminator_mode == TFA_MODE_FULL &&
                   !state_reg.miss) begin
        state_next.miss = 1'b1; // a lone stray pulse is ignored
      end else begin
        realign = 1'b1;
        state_next.miss = 1'b0;
      end
    end
    if (realign) begin
      state_next.edge_cnt = 10'h000;
      state_next.locked = near;
    end
    start = (act && wrap && !realign) || (realign && state_reg.edge_cnt > TFA_EDGE_NEAR);

    // Output clocks measured from the sampled input clock
    // The 16M midpoint toggle carries up to one hclk of jitter on its edges;
    // a true multiplied clock would need an analog loop outside this block
    if (any_edge) begin
      state_next.half_len = state_reg.half_cnt;
      state_next.half_cnt = 8'h00;
      state_next.c16 = ~state_reg.c16;
    end else begin
      if (state_reg.half_cnt != 8'hFF) begin
        state_next.half_cnt = state_reg.half_cnt + 8'h01;
      end
      if (state_reg.half_len != 8'h00 && state_reg.half_cnt == {1'b0, state_reg.half_len[7:1]}) begin
        state_next.c16 = ~state_reg.c16;
      end
    end
    if (any_edge && state_reg.fp8_hold != 3'h0) begin
      state_next.fp8_hold = state_reg.fp8_hold - 3'h1;
    end
    if (any_edge && state_reg.fp16_hold != 3'h0) begin
      state_next.fp16_hold = state_reg.fp16_hold - 3'h1;
    end

    // Frame start: bank turn, output timing restart, settings applied
    if (start) begin
      state_next.bank = (state_reg.bank == TFA_BANK_LAST) ? 2'h0 : state_reg.bank + 2'h1;
      state_next.cflip = state_reg.clk_s2 ^ state_reg.ctrl_act.out_clock_polarity_sel;
      state_next.c16 = state_reg.ctrl_act.out_clock_polarity_sel;
      state_next.fp8_hold = state_reg.ctrl_act.pulse_width_sel ? TFA_FP8_DOUBLE : TFA_FP8_SINGLE;
      state_next.fp16_hold = state_reg.ctrl_act.pulse_width_sel ? TFA_FP16_DOUBLE :
                             TFA_FP16_SINGLE;
    end
    // 8M clock is the synced link clock, flipped with the new inversion so it
    // shows the chosen polarity in the very cycle of the frame start
    state_next.c8 = state_reg.clk_s2 ^ state_next.cflip;
    // Settings wait for a boundary once framing is held; before that they apply at once
    if (start || !state_reg.locked) begin
      state_next.ctrl_act = state_reg.ctrl;
      for (int i = 0; i < TFA_STREAMS; i++) begin
        state_next.smp[i] = tfa_pos(state_reg.lid[i], state_reg.ctrl.sample_mode_sel);
        state_next.smp[i+TFA_STREAMS] = tfa_pos(state_reg.bid[i],
                                                state_reg.ctrl.sample_mode_sel);
      end
    end
    // Output pulses take the detected style: GCI when idle level is low
    state_next.fp8_o = (state_next.fp8_hold != 3'h0) ^ state_reg.lvl[3];
    state_next.fp16_o = (state_next.fp16_hold != 3'h0) ^ state_reg.lvl[3];
    state_next.chan = state_next.edge_cnt[9:1];
    state_next.rbank = (state_next.bank == TFA_BANK_LAST) ? 2'h0 : state_next.bank + 2'h1;

    // Per-channel output control for both ports
    state_next.lout = tfa_sw(local_cm, local_dm_byte, bp_dm_byte);
    state_next.bout = tfa_sw(bp_cm, local_dm_byte, bp_dm_byte);

    // AHB-Lite slave: zero wait states, write lands in the data phase
    // No access ever stalls, so hreadyout is tied high and hresp stays OKAY
    aphase = hsel && htrans[1] && hready;
    a = haddr[11:0];
    if (state_reg.wr_pend) begin
      fld = hwdata[4:0];
      if (state_reg.wr_addr == TFA_CTRL_OFS) begin
        state_next.ctrl = hwdata[7:0];
      end else if ((state_reg.wr_addr & TFA_BANK_MASK) == TFA_LID_BASE) begin
        state_next.lid[state_reg.wr_addr[5:2]] = fld;
      end else if ((state_reg.wr_addr & TFA_BANK_MASK) == TFA_BID_BASE) begin
        state_next.bid[state_reg.wr_addr[5:2]] = fld;
      end
    end
    state_next.wr_pend = aphase && hwrite;
    state_next.wr_addr = {a[11:2], 2'b00};
    // Read data is built in the address phase so that it leaves a flop
    state_next.rdata = 32'h0000_0000;
    if (aphase && !hwrite) begin
      if (a[11:2] == TFA_CTRL_OFS[11:2]) begin
        state_next.rdata = {24'h00_0000, state_reg.ctrl};
      end else if (a[11:2] == TFA_STAT_OFS[11:2]) begin
        state_next.rdata = {27'h000_0000, ~state_reg.lvl[3], state_reg.locked,
                            state_reg.miss, state_reg.bank};
      end else if ((a & TFA_BANK_MASK) == TFA_LID_BASE) begin
        state_next.rdata = {27'h000_0000, state_reg.lid[a[5:2]]};
      end else if ((a & TFA_BANK_MASK) == TFA_BID_BASE) begin
        state_next.rdata = {27'h000_0000, state_reg.bid[a[5:2]]};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Whole state resets to constants; straps are not sampled here
  // Edge flops clear to zero, so a high link clock gives one rise after reset;
  // it is harmless because the falling edge is the active one by default
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
      state_reg.lvl <= TFA_LVL_RST;
      state_reg.ctrl <= TFA_CTRL_RST;
      state_reg.ctrl_act <= TFA_CTRL_RST;
      state_reg.lid <= {TFA_STREAMS{TFA_DELAY_RST}};
      state_reg.bid <= {TFA_STREAMS{TFA_DELAY_RST}};
      state_reg.smp <= {2*TFA_STREAMS{TFA_FRAC_BASE}};
      state_reg.lout.oe_n <= 1'b1;
      state_reg.bout.oe_n <= 1'b1;
      state_reg.fp8_o <= 1'b1;
      state_reg.fp16_o <= 1'b1;
      state_reg.rbank <= 2'h1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops except the tied hreadyout and hresp
  // ----------------------------------------------------------------
  assign hrdata = state_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign frame_pulse_out_8m = state_reg.fp8_o;
  assign frame_pulse_out_16m = state_reg.fp16_o;
  assign clock_out_8m = state_reg.c8;
  assign clock_out_16m = state_reg.c16;
  assign channel_num = state_reg.chan;
  assign wr_bank = state_reg.bank;
  assign rd_bank = state_reg.rbank;
  assign sample_pos = state_reg.smp;
  assign local_out = state_reg.lout;
  assign bp_out = state_reg.bout;

endmodule : tfa_frame_align

/* File: dv/tfa_frame_align_assertions.sv */
// Port checker for the frame timing and input alignment block
`timescale 1ns/1ps

module tfa_frame_align_assertions
  import tfa_pkg::*;
(
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic [31:0] hrdata,
  input logic [8:0] channel_num,
  input logic [1:0] wr_bank,
  input logic [1:0] rd_bank,
  input logic frame_pulse_out_8m,
  input logic frame_pulse_out_16m,
  input tfa_pos_t sample_pos,
  input tfa_cm_t local_cm,
  input tfa_cm_t bp_cm,
  input logic [7:0] local_dm_byte,
  input logic [7:0] bp_dm_byte,
  input tfa_swout_t local_out,
  input tfa_swout_t bp_out
);
  // ------------------------------
  // Helper logic
  // ------------------------------
  function automatic tfa_swout_t sw(input tfa_cm_t c, input logic [7:0] l, input logic [7:0] b);
    return {(c.msg_mode_bit ? c.msg_byte : (c.source_sel_bit ? b : l)), !c.out_enable_bit};
  endfunction : sw

  tfa_swout_t exp_l_reg;
  tfa_swout_t exp_b_reg;
  logic [1:0] nxt_bank;

  // Expected channel words trail their inputs by one cycle
  always_ff @(posedge hclk) begin
    exp_l_reg <= sw(local_cm, local_dm_byte, bp_dm_byte);
    exp_b_reg <= sw(bp_cm, local_dm_byte, bp_dm_byte);
  end

  // Bank cycle has three steps, so the bank read is the one after the bank written
  assign nxt_bank = (wr_bank == 2'h2) ? 2'h0 : wr_bank + 2'h1;

  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_LOCAL_OUT: assert property ($past(hresetn) |-> local_out == exp_l_reg)
    else $error("local channel word wrong");
  AST_BP_OUT: assert property ($past(hresetn) |-> bp_out == exp_b_reg)
    else $error("backplane channel word wrong");
  AST_BANK_CH0: assert property ($changed(wr_bank) |-> channel_num == 9'h000)
    else $error("frame start not at channel zero");
  AST_BANK_STEP: assert property ($changed(wr_bank) |->
    wr_bank == $past(nxt_bank) && rd_bank == nxt_bank) else $error("bank step wrong");
  AST_FP_PAIR: assert property ($changed(wr_bank) |->
    frame_pulse_out_8m == frame_pulse_out_16m) else $error("frame pulses not aligned");
  AST_FP8_HOLD: assert property ($changed(wr_bank) |=> $stable(frame_pulse_out_8m) [*8])
    else $error("frame pulse too short");
  AST_RST_POS: assert property ($rose(hresetn) |->
    sample_pos[0] == 6'h03 && sample_pos[31] == 6'h03) else $error("reset sample point wrong");
  AST_RDATA_IDLE: assert property (!(hsel && htrans[1] && hready && !hwrite) |=>
    hrdata == 32'h0000_0000) else $error("read data without a read");
endmodule : tfa_frame_align_assertions

bind tfa_frame_align tfa_frame_align_assertions u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .channel_num(channel_num), .wr_bank(wr_bank),
  .rd_bank(rd_bank), .frame_pulse_out_8m(frame_pulse_out_8m), .sample_pos(sample_pos),
  .frame_pulse_out_16m(frame_pulse_out_16m), .local_cm(local_cm), .bp_cm(bp_cm),
  .local_dm_byte(local_dm_byte), .bp_dm_byte(bp_dm_byte), .local_out(local_out),
  .bp_out(bp_out));

/* File: dv/tfa_link_model.sv */
// Timing master model: free-running link clock and frame pulse
`timescale 1ns/1ps

module tfa_link_model #(
  parameter bit GCI = 1'h0,
  parameter bit DBL = 1'h0
) (
  output logic link_clk,
  output logic link_fp
);
  // ------------------------------
  // Half-period stepper
  // ------------------------------
  int h = 1848;
  logic act;

  // Pulse straddles the active edge; start offset keeps the first pulse out of reset
  always begin
    act = ((h + GCI + (DBL ? 2 : 0)) % 2048) < (DBL ? 4 : 2);
    link_clk = (h % 2 == 0);
    link_fp = GCI ? act : !act;
    #80;
    h = (h + 1) % 2048;
  end
endmodule : tfa_link_model

/* File: dv/tfa_frame_align_tb_top.sv */
// Self-checking bench for the frame timing and input alignment block
`timescale 1ns/1ps

module tfa_frame_align_tb_top
  import tfa_pkg::*;
;
  // ------------------------------
  // Signals
  // ------------------------------
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout, hresp, master_clock_in, master_frame_pulse_in;
  wire hready = hreadyout;
  logic fp8, fp16, c8, c16;
  logic [8:0] channel_num;
  logic [1:0] wr_bank, rd_bank, b0;
  tfa_pos_t sample_pos;
  tfa_cm_t local_cm = '0;
  tfa_cm_t bp_cm = '0;
  logic [7:0] local_dm_byte = 8'h0;
  logic [7:0] bp_dm_byte = 8'h0;
  tfa_swout_t local_out, bp_out;
  logic [31:0] rd, r, s;
  logic [31:0] seed = 32'h1B;
  logic [11:0] a;
  logic [4:0] f;
  logic [4:0] fld [32] = '{default: 5'h0};
  logic m;
  int error_cnt = 0;
  int check_count = 0;
  int idx, cnt, mx, lo8, lo16;

  always #2 hclk = ~hclk;

  tfa_frame_align u_tfa_frame_align (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .master_clock_in(master_clock_in),
    .master_frame_pulse_in(master_frame_pulse_in), .frame_pulse_out_8m(fp8),
    .frame_pulse_out_16m(fp16), .clock_out_8m(c8), .clock_out_16m(c16),
    .channel_num(channel_num), .wr_bank(wr_bank), .rd_bank(rd_bank), .sample_pos(sample_pos),
    .local_cm(local_cm), .bp_cm(bp_cm), .local_dm_byte(local_dm_byte),
    .bp_dm_byte(bp_dm_byte), .local_out(local_out), .bp_out(bp_out));

  tfa_link_model u_tfa_link_model (.link_clk(master_clock_in), .link_fp(master_frame_pulse_in));

  // ------------------------------
  // Reference model and helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Sample position in quarter bits from mode and delay field
  function automatic logic [5:0] pos(input logic sm, input logic [4:0] v);
    int q;
    q = (v[1:0] == 1) ? 4 : (v[1:0] + 3) % 4;
    return sm ? 6'(4 * v[4:2] + q) : 6'(3 + v);
  endfunction : pos

  // Channel word {data, oe_n}; message byte overrides memory data
  function automatic logic [31:0] swo(input logic [10:0] c, input logic [7:0] l, input logic [7:0] b);
    int d;
    d = c[10] ? c[7:0] : (c[8] ? b : l);
    return 32'(d * 2 + !c[9]);
  endfunction : swo

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Single AHB transfer; entered just after a rising edge, leaves the bus idle
  task automatic bus(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, ad};
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : bus

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, TFA_CTRL_OFS, 32'h0);
    check("ctrl_rst", rd, 32'h0);
    check("hresp", 32'(hresp), 32'h0);
    check("pos_rst", 32'(sample_pos[0]), 32'h3);
    bus(1'h1, 12'h100, 32'hFFFF_FFFF);
    bus(1'h0, 12'h100, 32'h0);
    check("unmapped", rd, 32'h0);
    // Settings apply at once before the first frame pulse is seen
    for (int k = 0; k < 16; k++) begin
      m = k[3];
      bus(1'h1, TFA_CTRL_OFS, {24'hABCDEF, m, 7'h00});
      r = rnd();
      if (k % 8 == 7) r[4:0] = 5'h1F;
      idx = r[12:8];
      f = r[4:0];
      a = (idx < 16) ? TFA_LID_BASE + 12'(4 * idx) : TFA_BID_BASE + 12'(4 * idx - 64);
      bus(1'h1, a, r);
      bus(1'h0, a, 32'h0);
      check("delay", rd, {27'h0, f});
      fld[idx] = f;
      repeat (3) @(posedge hclk);
      check("pos", 32'(sample_pos[idx]), 32'(pos(m, f)));
    end
    bus(1'h1, TFA_CTRL_OFS, 32'h0);
    $display("registers done");
    for (int k = 0; k < 40; k++) begin
      @(posedge hclk);
      r = rnd();
      s = rnd();
      local_cm <= r[10:0];
      bp_cm <= s[10:0];
      local_dm_byte <= r[31:24];
      bp_dm_byte <= s[31:24];
      @(posedge hclk);
      @(negedge hclk);
      check("local_out", 32'(local_out), swo(r[10:0], r[31:24], s[31:24]));
      check("bp_out", 32'(bp_out), swo(s[10:0], r[31:24], s[31:24]));
    end
    $display("channel path done");
    b0 = wr_bank;
    cnt = 0;
    while (wr_bank === b0 && cnt < 50000) begin
      @(negedge hclk);
      cnt++;
    end
    check("bank", 32'({wr_bank, rd_bank}), 32'h6);
    check("chan", 32'(channel_num), 32'h0);
    check("fp_start", 32'({fp8, fp16}), 32'h0);
    check("clk_pol", 32'({c8, c16}), 32'h0);
    lo8 = 1;
    lo16 = 1;
    // Pulse widths are counted while the status read goes on
    fork
      repeat (99) begin
        @(negedge hclk);
        lo8 += (fp8 === 1'h0);
        lo16 += (fp16 === 1'h0);
      end
      begin
        @(posedge hclk);
        bus(1'h0, TFA_STAT_OFS, 32'h0);
        // First pulse has no flywheel to agree with, so framing is not held yet
        check("status", 32'(rd[4:0]), 32'h01);
      end
    join
    check("fp_width", 32'(lo8 > 38 && lo8 < 42 && lo16 > 18 && lo16 < 22), 32'h1);
    b0 = wr_bank;
    cnt = 100;
    mx = 0;
    while (wr_bank === b0 && cnt < 50000) begin
      @(negedge hclk);
      cnt++;
      if (channel_num > mx) mx = channel_num;
    end
    check("frame_len", 32'(cnt > 40957 && cnt < 40963), 32'h1);
    check("chan_max", 32'(mx), 32'h1FF);
    check("bank2", 32'({wr_bank, rd_bank}), 32'h8);
    // Second pulse agrees with the flywheel: framing is held, settings now wait
    @(posedge hclk);
    bus(1'h1, TFA_CTRL_OFS, 32'h78);
    bus(1'h0, TFA_STAT_OFS, 32'h0);
    check("status2", 32'(rd[4:0]), 32'h0A);
    f = ~fld[1];
    bus(1'h1, TFA_LID_BASE + 12'h004, {27'h0, f});
    repeat (5) @(posedge hclk);
    check("hold", 32'(sample_pos[1]), 32'(pos(1'h0, fld[1])));
    b0 = wr_bank;
    cnt = 0;
    while (wr_bank === b0 && cnt < 50000) begin
      @(negedge hclk);
      cnt++;
    end
    check("bank3", 32'({wr_bank, rd_bank}), 32'h1);
    check("clk_pol3", 32'({c8, c16}), 32'h0);
    repeat (3) @(negedge hclk);
    check("applied", 32'(sample_pos[1]), 32'(pos(1'h0, f)));
    @(posedge hclk);
    bus(1'h0, TFA_STAT_OFS, 32'h0);
    check("status3", 32'(rd[4:0]), 32'h08);
    $display("frame timing done");
    finish_test();
  end

  // Watchdog past the lead-in and two frames of the link clock (about 86000)
  initial begin
    repeat (95000) @(posedge hclk);
    error_cnt++;
    finish_test();
  end
endmodule : tfa_frame_align_tb_top
